// ### logic/dmsb_pkg.sv
// Package: constants for the mode-register decode and speed-bin timing checks
package dmsb_pkg;
  // Clock period and cycle conversion (least times round up, longest round down)
  localparam int CLK_PS = 20000;
  function automatic int cyc_up(input int ps);
    return ((ps + CLK_PS - 1) / CLK_PS < 1) ? 1 : (ps + CLK_PS - 1) / CLK_PS;
  endfunction
  function automatic int cyc_dn(input int ps);
    return (ps / CLK_PS < 1) ? 1 : ps / CLK_PS;
  endfunction

  // Array timing in picoseconds, figures as printed
  localparam int TAA_MIN_FAST_PS  = 13750;
  localparam int TAA_MIN_SLOW_PS  = 13125;
  localparam int TAA_MAX_PS       = 20000;
  localparam int TRCD_FAST_PS     = 13750;
  localparam int TRCD_SLOW_PS     = 13125;
  localparam int TRC_FAST_PS      = 48750;
  localparam int TRC_SLOW_PS      = 49125;
  localparam int TRAS_MIN_FAST_PS = 35000;
  localparam int TRAS_MIN_SLOW_PS = 36000;
  localparam int TREFI_PS         = 7800000;
  localparam int TRAS_MAX_PS      = 9 * TREFI_PS;

  localparam int TAA_FAST_CYC     = cyc_up(TAA_MIN_FAST_PS);
  localparam int TAA_SLOW_CYC     = cyc_up(TAA_MIN_SLOW_PS);
  localparam int TAA_MAX_CYC      = cyc_dn(TAA_MAX_PS);
  localparam int TRCD_FAST_CYC    = cyc_up(TRCD_FAST_PS);
  localparam int TRCD_SLOW_CYC    = cyc_up(TRCD_SLOW_PS);
  localparam int TRC_FAST_CYC     = cyc_up(TRC_FAST_PS);
  localparam int TRC_SLOW_CYC     = cyc_up(TRC_SLOW_PS);
  localparam int TRAS_FAST_CYC    = cyc_up(TRAS_MIN_FAST_PS);
  localparam int TRAS_SLOW_CYC    = cyc_up(TRAS_MIN_SLOW_PS);
  localparam int TRAS_MAX_CYC     = cyc_dn(TRAS_MAX_PS);

  // Average clock period bounds of the speed bins, in ps
  localparam logic [15:0] TCK_3300 = 16'h0CE4;
  localparam logic [15:0] TCK_2500 = 16'h09C4;
  localparam logic [15:0] TCK_1875 = 16'h0753;
  localparam logic [15:0] TCK_1500 = 16'h05DC;
  localparam logic [15:0] TCK_1250 = 16'h04E2;

  // Register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TCK    = 8'h04;
  localparam logic [7:0] REG_MR0    = 8'h08;
  localparam logic [7:0] REG_MR1    = 8'h0C;
  localparam logic [7:0] REG_MR2    = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_LAT    = 8'h18;

  // Field positions and reset values
  localparam int CTRL_FAST    = 0;
  localparam int CTRL_DOWNBIN = 1;
  localparam logic [1:0]  CTRL_RST = 2'h1;
  localparam logic [15:0] TCK_RST  = 16'h09C4;
  localparam logic [15:0] MR_RST   = 16'h0000;
  localparam int ST_RSV      = 0;
  localparam int ST_TRCD     = 1;
  localparam int ST_TRC      = 2;
  localparam int ST_TRAS_MIN = 3;
  localparam int ST_TRAS_MAX = 4;
  localparam int ST_TCK      = 5;

  // Mode-register address bits
  localparam int MR0_BT  = 3;
  localparam int MR0_PD  = 12;
  localparam int MR1_DLO = 1;
  localparam int MR1_DHI = 5;
  localparam int MR1_QOFF = 12;
  localparam int MR2_ASR = 6;
  localparam int MR2_SRT = 7;

  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;

  // Read-latency sequencer states
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_WAIT = 1'b1
  } dmsb_rd_t;
endpackage

// ### logic/dmsb_top.sv
// Mode-register decode, read latency and speed-bin timing checks of the SDRAM
//
// Summary of operation
// - MR0 A1:A0 = 00 gives fixed burst eight
// - MR1 A12 = 0 enables outputs; A5,A1 drive
// - MR1 A9,A6,A2 = 011 enables nominal termination
// - MR2 A10:A9 = 10 enables write termination
// - MR0 A12 picks slow or fast exit
// - MR2 A6 enables automatic self refresh
// - MR2 A7 picks extended self-refresh range
// - MR0 A3 = 0 gives sequential burst order
// - First read data within its latency window
// - Down-binned device meets the slower latency
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module dmsb_top #(
  parameter int CNT_W = 12
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] a,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  output logic             bl8_fixed,
  output logic             out_buf_en,
  output logic      [1:0]  drive_sel,
  output logic      [2:0]  rtt_nom_sel,
  output logic      [1:0]  rtt_wr_sel,
  output logic             pd_fast_exit,
  output logic             asr_en,
  output logic             srt_ext,
  output logic             burst_seq,
  output logic             first_data,
  output logic             tck_bad
);
  // Elaboration checks: counters must hold the longest row time
  if (CNT_W > 16 || (1 << CNT_W) - 1 <= dmsb_pkg::TRAS_MAX_CYC) begin : g_cnt_chk
    $error("CNT_W too small for the row-open limit");
  end
  if (dmsb_pkg::TAA_FAST_CYC > dmsb_pkg::TAA_MAX_CYC || dmsb_pkg::TAA_MAX_CYC > 15) begin : g_lat_chk
    $error("Read latency window unreachable at this clock");
  end

  localparam int AA_LO   = dmsb_pkg::TAA_SLOW_CYC;
  localparam int AA_HI   = dmsb_pkg::TAA_MAX_CYC;
  localparam int AA_SLOW = dmsb_pkg::TAA_SLOW_CYC;

  typedef struct packed {
    logic [22:0]                pin_s1;
    logic [22:0]                pin_s2;
    logic                       fast;
    logic                       downbin;
    logic [15:0]                tck_ps;
    logic [15:0]                mr0;
    logic [15:0]                mr1;
    logic [15:0]                mr2;
    logic                       bl8;
    logic                       obuf;
    logic [1:0]                 drv;
    logic [2:0]                 rnom;
    logic [1:0]                 rwr;
    logic                       pdf;
    logic                       asr;
    logic                       srt;
    logic                       seq;
    logic [4:0]                 sticky;
    logic                       tck_bad;
    dmsb_pkg::dmsb_rd_t         rd_st;
    logic [3:0]                 rd_cnt;
    logic                       first;
    logic [7:0]                 open;
    logic [7:0][CNT_W-1:0]      age;
    logic [31:0]                rdata;
  } dmsb_state_t;

  dmsb_state_t q_reg;
  dmsb_state_t q_next;

  // Commands as seen after the pin synchroniser
  logic [3:0]  cmd;
  logic [2:0]  cba;
  logic [15:0] ca;
  logic        mrs_ok;
  logic        rd_cmd;
  assign cmd    = q_reg.pin_s2[22:19];
  assign cba    = q_reg.pin_s2[18:16];
  assign ca     = q_reg.pin_s2[15:0];
  assign rd_cmd = (cmd == dmsb_pkg::CMD_RD);

  // Period window for a CAS latency; CL11 only on the fast grade
  function automatic logic cl_tck_ok(input logic [3:0] cl, input logic [15:0] t, input logic fast);
    unique case (cl)
      4'h6:         cl_tck_ok = t >= dmsb_pkg::TCK_2500 && t <= dmsb_pkg::TCK_3300;
      4'h7, 4'h8:   cl_tck_ok = t >= dmsb_pkg::TCK_1875 && t < dmsb_pkg::TCK_2500;
      4'h9, 4'hA:   cl_tck_ok = t >= dmsb_pkg::TCK_1500 && t < dmsb_pkg::TCK_1875;
      4'hB:         cl_tck_ok = fast && t >= dmsb_pkg::TCK_1250 && t < dmsb_pkg::TCK_1500;
      default:      cl_tck_ok = 1'b0;
    endcase
  endfunction

  // Period window for a CAS write latency
  function automatic logic cwl_tck_ok(input logic [3:0] cwl, input logic [15:0] t, input logic fast);
    unique case (cwl)
      4'h5:    cwl_tck_ok = t >= dmsb_pkg::TCK_2500 && t <= dmsb_pkg::TCK_3300;
      4'h6:    cwl_tck_ok = t >= dmsb_pkg::TCK_1875 && t < dmsb_pkg::TCK_2500;
      4'h7:    cwl_tck_ok = t >= dmsb_pkg::TCK_1500 && t < dmsb_pkg::TCK_1875;
      4'h8:    cwl_tck_ok = fast && t >= dmsb_pkg::TCK_1250 && t < dmsb_pkg::TCK_1500;
      default: cwl_tck_ok = 1'b0;
    endcase
  endfunction

  // Reserved mode encodings; slow grade lacks CL11 and CWL8
  function automatic logic mr_bad(input logic [1:0] sel, input logic [15:0] v, input logic fast);
    unique case (sel)
      2'h0:    mr_bad = v[1:0] == 2'h3 || v[2] || v[6:4] < 3'h2 || (!fast && v[6:4] == 3'h7);
      2'h1:    mr_bad = v[dmsb_pkg::MR1_DHI] || {v[9], v[6], v[2]} > 3'h5;
      2'h2:    mr_bad = v[5:3] > 3'h3 || (!fast && v[5:3] == 3'h3) || v[10:9] == 2'h3;
      default: mr_bad = 1'b0;
    endcase
  endfunction

  assign mrs_ok = cmd == dmsb_pkg::CMD_MRS && cba[2] == 1'b0 && !mr_bad(cba[1:0], ca, q_reg.fast);

  // All next-state logic
  always_comb begin
    logic [4:0]       set;
    logic [4:0]       clr;
    logic [3:0]       cl;
    logic [3:0]       cwl;
    logic [3:0]       lat;
    logic [CNT_W-1:0] trcd;
    logic [CNT_W-1:0] trc;
    logic [CNT_W-1:0] tras;
    logic [CNT_W-1:0] tmax;
    set    = '0;
    clr    = '0;
    q_next = q_reg;
    q_next.pin_s1 = {cs_n, ras_n, cas_n, we_n, ba, a};
    q_next.pin_s2 = q_reg.pin_s1;
    q_next.first  = 1'b0;
    q_next.rdata  = 32'h0000_0000;
    cl   = {1'b0, q_reg.mr0[6:4]} + 4'h4;
    cwl  = {1'b0, q_reg.mr2[5:3]} + 4'h5;
    // Down-binned parts run the slower access window
    lat  = (q_reg.fast && !q_reg.downbin) ? 4'(dmsb_pkg::TAA_FAST_CYC) : 4'(dmsb_pkg::TAA_SLOW_CYC);
    trcd = q_reg.fast ? CNT_W'(dmsb_pkg::TRCD_FAST_CYC) : CNT_W'(dmsb_pkg::TRCD_SLOW_CYC);
    trc  = q_reg.fast ? CNT_W'(dmsb_pkg::TRC_FAST_CYC) : CNT_W'(dmsb_pkg::TRC_SLOW_CYC);
    tras = q_reg.fast ? CNT_W'(dmsb_pkg::TRAS_FAST_CYC) : CNT_W'(dmsb_pkg::TRAS_SLOW_CYC);
    // First cycle past the longest row time; open exactly that long is legal
    tmax = CNT_W'(dmsb_pkg::TRAS_MAX_CYC + 1);

    // Mode register set; a reserved value is refused whole
    if (cmd == dmsb_pkg::CMD_MRS && !mrs_ok && cba[2] == 1'b0) begin
      set[dmsb_pkg::ST_RSV] = 1'b1;
    end
    if (mrs_ok) begin
      unique case (cba[1:0])
        2'h0: begin
          q_next.mr0 = ca;
          q_next.bl8 = ca[1:0] == 2'h0;
          q_next.seq = !ca[dmsb_pkg::MR0_BT];
          q_next.pdf = ca[dmsb_pkg::MR0_PD];
        end
        2'h1: begin
          q_next.mr1  = ca;
          q_next.obuf = !ca[dmsb_pkg::MR1_QOFF];
          q_next.drv  = {ca[dmsb_pkg::MR1_DHI], ca[dmsb_pkg::MR1_DLO]};
          q_next.rnom = {ca[9], ca[6], ca[2]};
        end
        2'h2: begin
          q_next.mr2 = ca;
          q_next.rwr = ca[10:9];
          q_next.asr = ca[dmsb_pkg::MR2_ASR];
          q_next.srt = ca[dmsb_pkg::MR2_SRT];
        end
        default: begin
        end
      endcase
    end

    // Live period check against both latencies
    q_next.tck_bad = !(cl_tck_ok(cl, q_reg.tck_ps, q_reg.fast) &&
                       cwl_tck_ok(cwl, q_reg.tck_ps, q_reg.fast));

    // Per-bank row age; saturates so a stale bank never trips
    for (int b = 0; b < 8; b++) begin
      if (q_reg.age[b] != '1) begin
        q_next.age[b] = q_reg.age[b] + 1'b1;
      end
      if (q_reg.open[b] && q_reg.age[b] == tmax) begin
        set[dmsb_pkg::ST_TRAS_MAX] = 1'b1;
      end
      if (cmd == dmsb_pkg::CMD_REF && q_reg.age[b] < trc) begin
        set[dmsb_pkg::ST_TRC] = 1'b1;
      end
      if (cmd == dmsb_pkg::CMD_PRE && (ca[10] || cba == 3'(b))) begin
        if (q_reg.open[b] && q_reg.age[b] < tras) begin
          set[dmsb_pkg::ST_TRAS_MIN] = 1'b1;
        end
        q_next.open[b] = 1'b0;
      end
    end
    if (cmd == dmsb_pkg::CMD_ACT) begin
      if (q_reg.age[cba] < trc) begin
        set[dmsb_pkg::ST_TRC] = 1'b1;
      end
      q_next.open[cba] = 1'b1;
      q_next.age[cba]  = CNT_W'(1); // A command k cycles later sees age k
    end
    if ((rd_cmd || cmd == dmsb_pkg::CMD_WR) && (!q_reg.open[cba] || q_reg.age[cba] < trcd)) begin
      set[dmsb_pkg::ST_TRCD] = 1'b1;
    end

    // First-data timer; a new read restarts it
    if (rd_cmd) begin
      if (lat == 4'h1) begin
        q_next.first = 1'b1;
        q_next.rd_st = dmsb_pkg::RD_IDLE;
      end else begin
        q_next.rd_st  = dmsb_pkg::RD_WAIT;
        q_next.rd_cnt = lat - 4'h1;
      end
    end else begin
      unique case (q_reg.rd_st)
        dmsb_pkg::RD_IDLE: begin
        end
        dmsb_pkg::RD_WAIT: begin
          if (q_reg.rd_cnt == 4'h1) begin
            q_next.first = 1'b1;
            q_next.rd_st = dmsb_pkg::RD_IDLE;
          end else begin
            q_next.rd_cnt = q_reg.rd_cnt - 4'h1;
          end
        end
      endcase
    end

    // Register writes; sticky status bits 4:0 clear on a written one
    if (bus_wr) begin
      unique case (bus_addr)
        dmsb_pkg::REG_CTRL: begin
          q_next.fast    = bus_wdata[dmsb_pkg::CTRL_FAST];
          q_next.downbin = bus_wdata[dmsb_pkg::CTRL_DOWNBIN];
        end
        dmsb_pkg::REG_TCK:    q_next.tck_ps = bus_wdata[15:0];
        dmsb_pkg::REG_STATUS: clr = bus_wdata[4:0];
        default: begin
        end
      endcase
    end
    // A new event in the clearing cycle survives
    q_next.sticky = (q_reg.sticky & ~clr) | set;

    // Register reads; data valid the cycle after the strobe
    if (bus_rd) begin
      unique case (bus_addr)
        dmsb_pkg::REG_CTRL:   q_next.rdata = {30'h0, q_reg.downbin, q_reg.fast};
        dmsb_pkg::REG_TCK:    q_next.rdata = {16'h0000, q_reg.tck_ps};
        dmsb_pkg::REG_MR0:    q_next.rdata = {16'h0000, q_reg.mr0};
        dmsb_pkg::REG_MR1:    q_next.rdata = {16'h0000, q_reg.mr1};
        dmsb_pkg::REG_MR2:    q_next.rdata = {16'h0000, q_reg.mr2};
        dmsb_pkg::REG_STATUS: q_next.rdata = {26'h0, q_reg.tck_bad, q_reg.sticky};
        dmsb_pkg::REG_LAT:    q_next.rdata = {20'h0, cwl, cl, lat};
        default:              q_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_reg         <= '0;
      q_reg.pin_s1  <= {4'hF, 19'h0_0000}; // Flush as deselect so no false MRS follows reset
      q_reg.pin_s2  <= {4'hF, 19'h0_0000};
      q_reg.fast    <= dmsb_pkg::CTRL_RST[dmsb_pkg::CTRL_FAST];
      q_reg.downbin <= dmsb_pkg::CTRL_RST[dmsb_pkg::CTRL_DOWNBIN];
      q_reg.tck_ps  <= dmsb_pkg::TCK_RST;
      q_reg.mr0     <= dmsb_pkg::MR_RST;
      q_reg.mr1     <= dmsb_pkg::MR_RST;
      q_reg.mr2     <= dmsb_pkg::MR_RST;
      q_reg.bl8     <= 1'b1;
      q_reg.obuf    <= 1'b1;
      q_reg.seq     <= 1'b1;
      q_reg.tck_bad <= 1'b1;
      q_reg.rd_st   <= dmsb_pkg::RD_IDLE;
      q_reg.age     <= '1;
    end else begin
      q_reg <= q_next;
    end
  end

  // Outputs straight from the state register
  assign bus_rdata    = q_reg.rdata;
  assign bl8_fixed    = q_reg.bl8;
  assign out_buf_en   = q_reg.obuf;
  assign drive_sel    = q_reg.drv;
  assign rtt_nom_sel  = q_reg.rnom;
  assign rtt_wr_sel   = q_reg.rwr;
  assign pd_fast_exit = q_reg.pdf;
  assign asr_en       = q_reg.asr;
  assign srt_ext      = q_reg.srt;
  assign burst_seq    = q_reg.seq;
  assign first_data   = q_reg.first;
  assign tck_bad      = q_reg.tck_bad;

  // Mode decode checks tie each output to the accepted command word, rtt_nom_sel only for the value 011
  bl8_decode_a: assert property (@(posedge mclk) disable iff (rst)
    mrs_ok && cba[1:0] == 2'h0 |=> bl8_fixed == ($past(ca[1:0]) == 2'h0))
    else $error("burst length decode wrong");
  obuf_drive_a: assert property (@(posedge mclk) disable iff (rst)
    mrs_ok && cba[1:0] == 2'h1 |=> out_buf_en != $past(ca[12]) && drive_sel == $past({ca[5], ca[1]}))
    else $error("output buffer or drive decode wrong");
  rtt_nom_a: assert property (@(posedge mclk) disable iff (rst)
    mrs_ok && cba[1:0] == 2'h1 && {ca[9], ca[6], ca[2]} == 3'h3 |=> rtt_nom_sel == 3'h3)
    else $error("nominal termination not enabled");
  rtt_write_a: assert property (@(posedge mclk) disable iff (rst)
    mrs_ok && cba[1:0] == 2'h2 |=> rtt_wr_sel == $past(ca[10:9]) ##1 rtt_wr_sel == $past(ca[10:9], 2))
    else $error("write termination decode wrong");
  pd_exit_a: assert property (@(posedge mclk) disable iff (rst)
    mrs_ok && cba[1:0] == 2'h0 |=> pd_fast_exit == $past(ca[12]))
    else $error("power-down exit decode wrong");
  asr_mode_a: assert property (@(posedge mclk) disable iff (rst)
    !(cmd == dmsb_pkg::CMD_MRS && cba == 3'h2) |=> $stable(asr_en))
    else $error("self refresh enable moved without a mode write");
  srt_range_a: assert property (@(posedge mclk) disable iff (rst)
    mrs_ok && cba[1:0] == 2'h2 |=> srt_ext == $past(ca[7]) && asr_en == $past(ca[6]))
    else $error("self refresh range decode wrong");
  burst_order_a: assert property (@(posedge mclk) disable iff (rst)
    mrs_ok && cba[1:0] == 2'h0 |=> burst_seq != $past(ca[3]))
    else $error("burst order decode wrong");
  rd_window_a: assert property (@(posedge mclk) disable iff (rst)
    rd_cmd |-> ##[AA_LO:AA_HI] first_data)
    else $error("first read data outside its window");
  downbin_lat_a: assert property (@(posedge mclk) disable iff (rst)
    rd_cmd && (q_reg.downbin || !q_reg.fast) |-> ##AA_SLOW first_data)
    else $error("down-binned read latency wrong");
endmodule // dmsb_top

// ### testbench/dmsb_ctrl_model.sv
// Behavioural memory-controller model that drives the command pins
`timescale 1ns/1ps
module dmsb_ctrl_model (
  input  wire logic        mclk,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic      [2:0]  ba,
  output logic      [15:0] a
);
  int cyc;
  int act_at [8];
  bit rude;

  // Cycle count used to space commands per bank
  always @(posedge mclk) begin
    cyc <= cyc + 1;
  end

  // Deselected at start; every row counts as long closed
  initial begin
    cyc = 0;
    rude = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    a = 16'h0000;
    foreach (act_at[i]) begin
      act_at[i] = -100000;
    end
  end

  // One command per call, entered after a rising edge; spacing is skipped for MRS and when told to misbehave
  task automatic send(input logic [3:0] cmd, input logic [2:0] bk, input logic [15:0] ad);
    int gap;
    gap = 0;
    if (cmd == dmsb_pkg::CMD_RD || cmd == dmsb_pkg::CMD_WR) begin
      gap = dmsb_pkg::TRCD_FAST_CYC;
    end
    if (cmd == dmsb_pkg::CMD_ACT || cmd == dmsb_pkg::CMD_REF) begin
      gap = dmsb_pkg::TRC_FAST_CYC;
    end
    if (cmd == dmsb_pkg::CMD_PRE) begin
      gap = dmsb_pkg::TRAS_FAST_CYC;
    end
    while (!rude && cmd != dmsb_pkg::CMD_MRS && cyc - act_at[bk] < gap) begin
      @(posedge mclk);
    end
    {cs_n, ras_n, cas_n, we_n} <= cmd;
    ba <= bk;
    a <= ad; // Mode words come from the caller, legal unless a refusal is wanted
    if (cmd == dmsb_pkg::CMD_ACT) begin
      act_at[bk] = cyc;
    end
    @(posedge mclk);
  endtask

  // Deselect holds cs_n high; the other pins show the inverse of the last value, never a held copy
  task automatic idle();
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
    ba <= ~ba;
    a <= ~a;
    @(posedge mclk);
  endtask
endmodule // dmsb_ctrl_model

// ### testbench/dmsb_top_tb_top.sv
// Self-checking bench: mode decode, read latency, period window and timing flags
`timescale 1ns/1ps
module dmsb_top_tb_top;
  logic        mclk;
  logic        rst;
  logic        cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba;
  logic [15:0] a;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic        bus_wr, bus_rd;
  logic        bl8_fixed, out_buf_en, pd_fast_exit, asr_en, srt_ext, burst_seq, first_data, tck_bad;
  logic [1:0]  drive_sel, rtt_wr_sel;
  logic [2:0]  rtt_nom_sel;
  int          err_count = 0;
  int          samples_checked = 0;
  // Mode register select and word, expected config vector in the low half
  logic [2:0]  mbk [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h1, 3'h2, 3'h0, 3'h2};
  logic [31:0] mtab [8] = '{32'h1020_1809, 32'h0029_0800, 32'h0046_0AC0, 32'h04C0_0AE6,
                            32'h1000_0026, 32'h0600_0026, 32'h1020_102F, 32'h0000_1009};
  // MR0 low byte, MR2 low byte, period in ps; last entry leaves a legal setting
  logic [31:0] ttab [11] = '{32'h2000_0CE4, 32'h2000_0CE5, 32'h3008_0753, 32'h3008_0752, 32'h4008_09C4,
                             32'h5010_05DC, 32'h6010_0753, 32'h7018_04E2, 32'h7018_05DC, 32'h3000_0753,
                             32'h2000_09C4};
  logic [10:0] texp = 11'h35A;
  wire  [12:0] cfg = {bl8_fixed, out_buf_en, drive_sel, rtt_nom_sel, rtt_wr_sel, pd_fast_exit, asr_en,
                      srt_ext, burst_seq};

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  dmsb_ctrl_model ctl (.mclk(mclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a));

  dmsb_top uut (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .bl8_fixed(bl8_fixed), .out_buf_en(out_buf_en), .drive_sel(drive_sel), .rtt_nom_sel(rtt_nom_sel),
    .rtt_wr_sel(rtt_wr_sel), .pd_fast_exit(pd_fast_exit), .asr_en(asr_en), .srt_ext(srt_ext),
    .burst_seq(burst_seq), .first_data(first_data), .tck_bad(tck_bad)
  );

  // Compare and count; four-state equality so unknowns fail
  task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One-cycle strobes; the idle edge after each keeps drivers from double assignment
  task automatic bus_write(input logic [7:0] ad, input logic [31:0] d);
    bus_addr <= ad;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    @(posedge mclk);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] ad, input logic [31:0] exp_v);
    bus_addr <= ad;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    check(bus_rdata, exp_v);
    @(posedge mclk);
  endtask

  // Mode set, then wait until its outputs have landed (sample edge plus three)
  task automatic mrs(input logic [2:0] bk, input logic [15:0] ad);
    ctl.send(dmsb_pkg::CMD_MRS, bk, ad);
    ctl.idle();
    settle(2);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("MISMATCH at %0t: run limit reached", $time);
    complete_run();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0000_0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check({19'h0, cfg}, 32'h0000_1801);
    @(posedge mclk);
    // Read-only image and unmapped place ignore writes
    bus_write(dmsb_pkg::REG_MR0, 32'h0000_FFFF);
    bus_write(8'h1C, 32'hFFFF_FFFF);
    bus_read(dmsb_pkg::REG_CTRL, 32'h0000_0001);
    bus_read(dmsb_pkg::REG_TCK, 32'h0000_09C4);
    bus_read(dmsb_pkg::REG_MR0, 32'h0000_0000);
    bus_read(8'h1C, 32'h0000_0000);
    bus_read(dmsb_pkg::REG_STATUS, 32'h0000_0020);
    // Every mode field set and cleared; entry five is reserved and dropped
    for (int i = 0; i < 8; i++) begin
      mrs(mbk[i], mtab[i][31:16]);
      check({19'h0, cfg}, {19'h0, mtab[i][12:0]});
    end
    bus_read(dmsb_pkg::REG_MR0, 32'h0000_1020);
    bus_read(dmsb_pkg::REG_STATUS, 32'h0000_0001);
    bus_write(dmsb_pkg::REG_STATUS, 32'h0000_0001);
    bus_read(dmsb_pkg::REG_STATUS, 32'h0000_0000);
    // Period window edges of each latency pair
    for (int i = 0; i < 11; i++) begin
      mrs(3'h0, {8'h00, ttab[i][31:24]});
      mrs(3'h2, {8'h00, ttab[i][23:16]});
      bus_write(dmsb_pkg::REG_TCK, {16'h0000, ttab[i][15:0]});
      settle(2);
      check({31'h0, tck_bad}, {31'h0, texp[i]});
    end
    bus_read(dmsb_pkg::REG_STATUS, 32'h0000_0000);
    bus_read(dmsb_pkg::REG_LAT, 32'h0000_0561);
    // Slow grade must refuse the fastest latency
    bus_write(dmsb_pkg::REG_CTRL, 32'h0000_0000);
    mrs(3'h0, 16'h0070);
    bus_read(dmsb_pkg::REG_STATUS, 32'h0000_0001);
    bus_read(dmsb_pkg::REG_MR0, 32'h0000_0020);
    // Fast grade with down-bin so the slower latency path is exercised
    bus_write(dmsb_pkg::REG_CTRL, 32'h0000_0003);
    bus_read(dmsb_pkg::REG_CTRL, 32'h0000_0003);
    bus_write(dmsb_pkg::REG_STATUS, 32'h0000_0001);
    // Legal open, read, close: first data on its cycle and no flags
    ctl.send(dmsb_pkg::CMD_ACT, 3'h0, 16'h0123);
    ctl.send(dmsb_pkg::CMD_RD, 3'h0, 16'h0010);
    ctl.idle();
    for (int k = 2; k < 5; k++) begin
      @(posedge mclk);
      #1;
      check({31'h0, first_data}, {31'h0, k == 2});
    end
    ctl.send(dmsb_pkg::CMD_PRE, 3'h0, 16'h0000);
    ctl.idle();
    settle(3);
    bus_read(dmsb_pkg::REG_STATUS, 32'h0000_0000);
    // Back-to-back violations of each spacing, then close every bank
    ctl.rude = 1'b1;
    ctl.send(dmsb_pkg::CMD_RD, 3'h5, 16'h0000);
    ctl.send(dmsb_pkg::CMD_ACT, 3'h1, 16'h0001);
    ctl.send(dmsb_pkg::CMD_ACT, 3'h1, 16'h0002);
    ctl.send(dmsb_pkg::CMD_ACT, 3'h2, 16'h0003);
    ctl.send(dmsb_pkg::CMD_PRE, 3'h2, 16'h0000);
    ctl.send(dmsb_pkg::CMD_PRE, 3'h0, 16'h0400);
    ctl.idle();
    settle(3);
    bus_read(dmsb_pkg::REG_STATUS, 32'h0000_000E);
    bus_write(dmsb_pkg::REG_STATUS, 32'h0000_001F);
    ctl.rude = 1'b0;
    // Row left open past the longest allowed time
    ctl.send(dmsb_pkg::CMD_ACT, 3'h3, 16'h0004);
    ctl.idle();
    settle(3520);
    ctl.send(dmsb_pkg::CMD_PRE, 3'h3, 16'h0000);
    ctl.idle();
    settle(3);
    bus_read(dmsb_pkg::REG_STATUS, 32'h0000_0010);
    complete_run();
  end
endmodule // dmsb_top_tb_top
